// file: rtl/syndrome_pkg.sv
// Constants for the register-file machine-check syndrome word.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package syndrome_pkg;

    // ****************************************************************
    // Word geometry
    // ****************************************************************
    localparam int WORD_W          = 64;
    localparam int SEL_LSB         = 0;
    localparam int SEL_W           = 4;
    localparam int ACC_LSB         = 4;
    localparam int ACC_W           = 4;
    localparam int REGNUM_LSB      = 8;
    localparam int REGNUM_W        = 7;
    localparam int REGNUM_VLD_BIT  = 15;
    localparam int RSVD_LO_LSB     = 16;
    localparam int RSVD_LO_MSB     = 53;
    localparam int ISET_BIT        = 54;
    localparam int ISET_VLD_BIT    = 55;
    localparam int PRIV_LSB        = 56;
    localparam int PRIV_W          = 2;
    localparam int PRIV_VLD_BIT    = 58;
    localparam int CORRECTED_BIT   = 59;
    localparam int TARGET_VLD_BIT  = 60;
    localparam int REQ_VLD_BIT     = 61;
    localparam int RESP_VLD_BIT    = 62;
    localparam int PRECISE_BIT     = 63;

    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [3:0]  SEL_UNCLASSIFIED = 4'h0;
    localparam logic [3:0]  SEL_LAST_DEFINED = 4'hD;
    localparam logic [3:0]  ACC_UNKNOWN      = 4'h0;
    localparam logic [3:0]  ACC_READ         = 4'h1;
    localparam logic [3:0]  ACC_WRITE        = 4'h2;
    localparam logic [63:0] WORD_RESET       = 64'h0000_0000_0000_0000;
    localparam int          COUNT_W          = 8;

endpackage : syndrome_pkg

// file: rtl/syndrome_fields_if.sv
// Carries the assembled syndrome word from the encoder to the capture store.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface syndrome_fields_if;
    logic [63:0] word;
    logic        selectReserved;

    modport encoder (output word, output selectReserved);
    modport store   (input  word, input  selectReserved);
endinterface : syndrome_fields_if

// file: rtl/syndrome_field_encoder.sv
// Combinational packing of the raw error fields into the 64-bit layout.
// Assumes the inputs are stable for the cycle in which they are captured.
`timescale 1ns/10ps
module syndrome_field_encoder (
    // Raw fields of the reported error
    input  wire logic [3:0] regfileSelectCode,
    input  wire logic [3:0] accessKindCode,
    input  wire logic [6:0] regNumber,
    input  wire logic       regNumberValid,
    input  wire logic       instructionSetFlag,
    input  wire logic       instructionSetValid,
    input  wire logic [1:0] privilegeLevelField,
    input  wire logic       privilegeValid,
    input  wire logic       corrected,
    input  wire logic       precisePointerLogged,
    // Packed word toward the store
    syndrome_fields_if.encoder fields
);

    logic [3:0] selCode;

    // Reserved selector codes are folded into unclassified so software never sees them.
    always_comb begin
        fields.selectReserved = (regfileSelectCode > syndrome_pkg::SEL_LAST_DEFINED);
        selCode = fields.selectReserved ? syndrome_pkg::SEL_UNCLASSIFIED : regfileSelectCode;
    end

    // Every bit not named below stays zero, including the address and identifier flags.
    always_comb begin
        fields.word = syndrome_pkg::WORD_RESET;
        fields.word[syndrome_pkg::SEL_LSB +: syndrome_pkg::SEL_W] = selCode;
        fields.word[syndrome_pkg::ACC_LSB +: syndrome_pkg::ACC_W] = accessKindCode;
        // A meaningless register number is zeroed rather than leaked.
        fields.word[syndrome_pkg::REGNUM_LSB +: syndrome_pkg::REGNUM_W] =
            regNumberValid ? regNumber : 7'h00;
        fields.word[syndrome_pkg::REGNUM_VLD_BIT] = regNumberValid;
        fields.word[syndrome_pkg::ISET_BIT] = instructionSetValid & instructionSetFlag;
        fields.word[syndrome_pkg::ISET_VLD_BIT] = instructionSetValid;
        fields.word[syndrome_pkg::PRIV_LSB +: syndrome_pkg::PRIV_W] =
            privilegeValid ? privilegeLevelField : 2'h0;
        fields.word[syndrome_pkg::PRIV_VLD_BIT] = privilegeValid;
        fields.word[syndrome_pkg::CORRECTED_BIT] = corrected;
        fields.word[syndrome_pkg::PRECISE_BIT] = precisePointerLogged;
    end

endmodule : syndrome_field_encoder

// file: rtl/syndrome_capture_store.sv
// Holds the captured syndrome word until software consumes it.
// Assumes load and clear come from the same clock domain.
`timescale 1ns/10ps
module syndrome_capture_store (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        load,
    input  wire logic        clear,
    // Word in and out
    syndrome_fields_if.store fields,
    output logic      [63:0] word_reg,
    output logic             reservedSeen_reg
);

    // A load in the same cycle as a clear wins, so a fresh error is never dropped.
    always_ff @(posedge clk) begin
        if (rst) begin
            word_reg <= syndrome_pkg::WORD_RESET;
        end else if (load) begin
            word_reg <= fields.word;
        end else if (clear) begin
            word_reg <= syndrome_pkg::WORD_RESET;
        end
    end

    // Remembers that the held word had its selector folded from a reserved code.
    always_ff @(posedge clk) begin
        if (rst) begin
            reservedSeen_reg <= 1'b0;
        end else if (load) begin
            reservedSeen_reg <= fields.selectReserved;
        end else if (clear) begin
            reservedSeen_reg <= 1'b0;
        end
    end

endmodule : syndrome_capture_store

// file: rtl/regfile_error_syndrome_word.sv
// Top of the register-file error syndrome logger.
// Assumes errors and acknowledges are synchronous one-cycle pulses on clk.
`timescale 1ns/10ps

// How it works
// - Low four bits name failing register file.
// - Bits 7:4 give the access kind.
// - Bits 14:8 hold the failing register number.
// - Bit 15 set only for meaningful number.
// - Bit 54: zero native, one legacy set.
// - Bit 55 marks instruction-set bit valid.
// - Bits 57:56 hold the bundle privilege level.
// - Bit 58 marks privilege field valid.
// - Bit 59 set when already corrected.
// - Bit 63 set when precise pointer captured.
// - Address, requester, responder flags always invalid.
module regfile_error_syndrome_word #(
    parameter int COUNT_W = syndrome_pkg::COUNT_W
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Error report from the register file checker
    input  wire logic               errorEvent,
    input  wire logic [3:0]         regfileSelectCode,
    input  wire logic [3:0]         accessKindCode,
    input  wire logic [6:0]         regNumber,
    input  wire logic               regNumberValid,
    input  wire logic               instructionSetFlag,
    input  wire logic               instructionSetValid,
    input  wire logic [1:0]         privilegeLevelField,
    input  wire logic               privilegeValid,
    input  wire logic               corrected,
    input  wire logic               precisePointerLogged,
    // Software consumption of the logged word
    input  wire logic               readAck,
    // Logged word and status
    output logic      [63:0]        errorInfo,
    output logic                    logValid,
    output logic                    overflow,
    output logic                    selectWasReserved,
    output logic      [COUNT_W-1:0] errorCount
);

    // ****************************************************************
    // Internal state
    // ****************************************************************
    syndrome_fields_if fieldsBus ();

    logic               logValid_reg;
    logic               overflow_reg;
    logic [COUNT_W-1:0] errorCount_reg;
    logic [63:0]        word_reg;
    logic               reservedSeen_reg;
    logic               heldCorrected;
    logic               acceptEvent;
    logic               loseEvent;

    // ****************************************************************
    // Field packing and storage
    // ****************************************************************
    syndrome_field_encoder u_encoder (
        .regfileSelectCode    (regfileSelectCode),
        .accessKindCode       (accessKindCode),
        .regNumber            (regNumber),
        .regNumberValid       (regNumberValid),
        .instructionSetFlag   (instructionSetFlag),
        .instructionSetValid  (instructionSetValid),
        .privilegeLevelField  (privilegeLevelField),
        .privilegeValid       (privilegeValid),
        .corrected            (corrected),
        .precisePointerLogged (precisePointerLogged),
        .fields               (fieldsBus.encoder)
    );

    syndrome_capture_store u_store (
        .clk              (clk),
        .rst              (rst),
        .load             (acceptEvent),
        .clear            (readAck),
        .fields           (fieldsBus.store),
        .word_reg         (word_reg),
        .reservedSeen_reg (reservedSeen_reg)
    );

    // ****************************************************************
    // Capture arbitration
    // ****************************************************************

    // An uncorrected error displaces a held corrected one, because it is the one
    // software must act on; otherwise the first error stays until acknowledged.
    assign heldCorrected = word_reg[syndrome_pkg::CORRECTED_BIT];
    assign acceptEvent   = errorEvent & (~logValid_reg | readAck | (heldCorrected & ~corrected));
    assign loseEvent     = errorEvent & ~acceptEvent;

    // Valid flag: set wins over the acknowledge in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            logValid_reg <= 1'b0;
        end else if (acceptEvent) begin
            logValid_reg <= 1'b1;
        end else if (readAck) begin
            logValid_reg <= 1'b0;
        end
    end

    // Overflow is sticky; an error in the acknowledge cycle is taken, not lost, so it clears.
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_reg <= 1'b0;
        end else if (loseEvent) begin
            overflow_reg <= 1'b1;
        end else if (readAck) begin
            overflow_reg <= 1'b0;
        end
    end

    // Counts every reported error, saturating so a storm cannot wrap to a small value.
    always_ff @(posedge clk) begin
        if (rst) begin
            errorCount_reg <= '0;
        end else if (errorEvent && (errorCount_reg != {COUNT_W{1'b1}})) begin
            errorCount_reg <= errorCount_reg + COUNT_W'(1);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All outputs come straight from flip-flops.
    assign errorInfo         = word_reg;
    assign logValid          = logValid_reg;
    assign overflow          = overflow_reg;
    assign selectWasReserved = reservedSeen_reg;
    assign errorCount        = errorCount_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_select_code;
        acceptEvent |=> errorInfo[3:0] ==
            (($past(regfileSelectCode) > syndrome_pkg::SEL_LAST_DEFINED) ? 4'h0 : $past(regfileSelectCode));
    endproperty
    a_select_code: assert property (p_select_code) else $error("Selector field wrong.");

    property p_select_defined;
        errorInfo[3:0] <= syndrome_pkg::SEL_LAST_DEFINED;
    endproperty
    a_select_defined: assert property (p_select_defined) else $error("Reserved selector shown.");

    property p_access_kind;
        acceptEvent |=> errorInfo[7:4] == $past(accessKindCode);
    endproperty
    a_access_kind: assert property (p_access_kind) else $error("Access kind wrong.");

    property p_reg_number;
        acceptEvent && regNumberValid |=> errorInfo[14:8] == $past(regNumber);
    endproperty
    a_reg_number: assert property (p_reg_number) else $error("Register number wrong.");

    property p_reg_valid;
        acceptEvent |=> errorInfo[15] == $past(regNumberValid) && (errorInfo[15] || errorInfo[14:8] == 7'h00);
    endproperty
    a_reg_valid: assert property (p_reg_valid) else $error("Register number flag wrong.");

    property p_iset;
        acceptEvent |=> errorInfo[54] == ($past(instructionSetFlag) && $past(instructionSetValid));
    endproperty
    a_iset: assert property (p_iset) else $error("Instruction set bit wrong.");

    property p_iset_valid;
        acceptEvent |=> errorInfo[55] == $past(instructionSetValid);
    endproperty
    a_iset_valid: assert property (p_iset_valid) else $error("Instruction set flag wrong.");

    property p_priv;
        acceptEvent && privilegeValid |=> errorInfo[57:56] == $past(privilegeLevelField);
    endproperty
    a_priv: assert property (p_priv) else $error("Privilege level wrong.");

    property p_priv_valid;
        acceptEvent |=> errorInfo[58] == $past(privilegeValid);
    endproperty
    a_priv_valid: assert property (p_priv_valid) else $error("Privilege flag wrong.");

    property p_corrected;
        acceptEvent |=> errorInfo[59] == $past(corrected);
    endproperty
    a_corrected: assert property (p_corrected) else $error("Corrected flag wrong.");

    property p_precise;
        acceptEvent |=> errorInfo[63] == $past(precisePointerLogged);
    endproperty
    a_precise: assert property (p_precise) else $error("Precise pointer flag wrong.");

    property p_ids_invalid;
        errorInfo[62:60] == 3'h0;
    endproperty
    a_ids_invalid: assert property (p_ids_invalid) else $error("Address or identifier flag set.");

    property p_reserved_zero;
        errorInfo[53:16] == 38'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set.");

    property p_hold_until_ack;
        logValid && !readAck && !errorEvent |=> $stable(errorInfo) && logValid;
    endproperty
    a_hold_until_ack: assert property (p_hold_until_ack) else $error("Logged word changed unprompted.");

    property p_set_wins;
        errorEvent && readAck |=> logValid && !overflow;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Error lost at acknowledge.");

    property p_overflow;
        logValid && errorEvent && !readAck && !(heldCorrected && !corrected) |=> overflow;
    endproperty
    a_overflow: assert property (p_overflow) else $error("Overflow not flagged.");

    // ****************************************************************
    // Reset, acknowledge, log-state and counter assertions
    // ****************************************************************
    // Reset carries its own disable, since the default one would mask it.
    property p_reset_clear;
        @(posedge clk) disable iff (1'b0)
        rst |=> errorInfo == 64'h0 && !logValid && !overflow && !selectWasReserved && errorCount == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("State not cleared by reset.");

    // An acknowledge with no new error empties the log completely.
    property p_ack_clears;
        readAck && !errorEvent |=>
            !logValid && !overflow && !selectWasReserved && errorInfo == 64'h0;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("Acknowledge left state behind.");

    // An empty log shows the all-zero word, so stale data never leaks out.
    property p_empty_is_zero;
        !logValid |-> errorInfo == 64'h0 && !selectWasReserved && !overflow;
    endproperty
    a_empty_is_zero: assert property (p_empty_is_zero) else $error("Empty log shows data.");

    // The first error into an empty log is always taken.
    property p_accept_empty;
        errorEvent && !logValid |=> logValid && !overflow;
    endproperty
    a_accept_empty: assert property (p_accept_empty) else $error("Error into empty log dropped.");

    // The valid flag only rises because of an error.
    property p_no_spurious_valid;
        !logValid && !errorEvent |=> !logValid;
    endproperty
    a_no_spurious_valid: assert property (p_no_spurious_valid) else $error("Log valid without an error.");

    // A dropped error must not disturb the word that software has yet to read.
    property p_lost_keeps_word;
        loseEvent |=> $stable(errorInfo) && logValid && overflow;
    endproperty
    a_lost_keeps_word: assert property (p_lost_keeps_word) else $error("Dropped error disturbed the log.");

    // Overflow stays up until software acknowledges.
    property p_overflow_sticky;
        overflow && !readAck |=> overflow;
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("Overflow cleared unprompted.");

    // An uncorrected error replaces a held corrected one.
    property p_displace;
        logValid && heldCorrected && errorEvent && !corrected |=>
            logValid && !errorInfo[syndrome_pkg::CORRECTED_BIT];
    endproperty
    a_displace: assert property (p_displace) else $error("Corrected word not displaced.");

    // The reserved-selector status follows the code taken with the error.
    property p_reserved_seen;
        acceptEvent |=> selectWasReserved == ($past(regfileSelectCode) > syndrome_pkg::SEL_LAST_DEFINED);
    endproperty
    a_reserved_seen: assert property (p_reserved_seen) else $error("Reserved selector status wrong.");

    // Every error adds one to the count, short of saturation.
    property p_count_step;
        errorEvent && errorCount != {COUNT_W{1'b1}} |=>
            errorCount == $past(errorCount) + COUNT_W'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("Error count did not step.");

    // Without an error the count stands.
    property p_count_hold;
        !errorEvent |=> $stable(errorCount);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("Error count moved without an error.");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    c_capture:    cover property (!logValid && errorEvent ##1 logValid ##[1:4] readAck);
    c_displace:   cover property (logValid && heldCorrected && errorEvent && !corrected);
    c_overflow:   cover property (logValid && errorEvent && !readAck ##1 overflow);
    c_ack_and_ev: cover property (errorEvent && readAck);
    c_reserved:   cover property (acceptEvent && regfileSelectCode > syndrome_pkg::SEL_LAST_DEFINED);

endmodule : regfile_error_syndrome_word

// file: tb/testbench.sv
// Self-checking bench for the register-file error syndrome logger.
// Assumes the design package and interface are compiled first; one 100 MHz clock.
`timescale 1ns/10ps

// Counts every comparison and reports a mismatch at once.
`define CHK(act, exp) begin testsRun++; if ((act) !== (exp)) begin errTotal++; \
    $display("[ERR] %0t got %h expected %h", $time, (act), (exp)); end end

module testbench;

    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic        clk                  = 1'b0;
    logic        rst                  = 1'b1;
    logic        errorEvent           = 1'b0;
    logic [3:0]  regfileSelectCode    = 4'h0;
    logic [3:0]  accessKindCode       = 4'h0;
    logic [6:0]  regNumber            = 7'h00;
    logic        regNumberValid       = 1'b0;
    logic        instructionSetFlag   = 1'b0;
    logic        instructionSetValid  = 1'b0;
    logic [1:0]  privilegeLevelField  = 2'h0;
    logic        privilegeValid       = 1'b0;
    logic        corrected            = 1'b0;
    logic        precisePointerLogged = 1'b0;
    logic        readAck              = 1'b0;
    logic [63:0] errorInfo;
    logic        logValid;
    logic        overflow;
    logic        selectWasReserved;
    logic [7:0]  errorCount;
    int          errTotal             = 0;
    int          testsRun             = 0;
    int          evCount              = 0;
    logic [63:0] held;

    // ****************************************************************
    // Clock, design and closing
    // ****************************************************************
    // Free-running clock at 100 MHz.
    always #5 clk = ~clk;

    regfile_error_syndrome_word dut_u (
        .clk                  (clk),
        .rst                  (rst),
        .errorEvent           (errorEvent),
        .regfileSelectCode    (regfileSelectCode),
        .accessKindCode       (accessKindCode),
        .regNumber            (regNumber),
        .regNumberValid       (regNumberValid),
        .instructionSetFlag   (instructionSetFlag),
        .instructionSetValid  (instructionSetValid),
        .privilegeLevelField  (privilegeLevelField),
        .privilegeValid       (privilegeValid),
        .corrected            (corrected),
        .precisePointerLogged (precisePointerLogged),
        .readAck              (readAck),
        .errorInfo            (errorInfo),
        .logValid             (logValid),
        .overflow             (overflow),
        .selectWasReserved    (selectWasReserved),
        .errorCount           (errorCount)
    );

    // Prints the verdict and ends the run.
    task automatic closeOut();
        if (errTotal == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : closeOut

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Expected word built from the present field inputs; invalid subfields read as zero.
    function automatic logic [63:0] expWord();
        logic [63:0] w;
        w         = 64'h0000_0000_0000_0000;
        w[3:0]    = (regfileSelectCode > 4'hD) ? 4'h0 : regfileSelectCode;
        w[7:4]    = accessKindCode;
        w[14:8]   = regNumberValid ? regNumber : 7'h00;
        w[15]     = regNumberValid;
        w[54]     = instructionSetValid & instructionSetFlag;
        w[55]     = instructionSetValid;
        w[57:56]  = privilegeValid ? privilegeLevelField : 2'h0;
        w[58]     = privilegeValid;
        w[59]     = corrected;
        w[63]     = precisePointerLogged;
        return w;
    endfunction : expWord

    // One error pulse; returns just after the edge that answers it.
    task automatic fire();
        @(posedge clk);
        #1 errorEvent = 1'b1;
        @(posedge clk);
        #1 errorEvent = 1'b0;
        evCount++;
    endtask : fire

    // One acknowledge pulse; the log must be empty afterwards.
    task automatic ack();
        @(posedge clk);
        #1 readAck = 1'b1;
        @(posedge clk);
        #1 readAck = 1'b0;
        `CHK(logValid, 1'b0)
        `CHK(errorInfo, 64'h0000_0000_0000_0000)
    endtask : ack

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Every selector code, reserved ones included, logs the right identifier.
    task automatic t_select();
        for (int i = 0; i < 16; i++) begin
            regfileSelectCode = i[3:0];
            fire();
            `CHK(errorInfo[3:0], expWord() >> 0 & 4'hF)
            `CHK(selectWasReserved, (i > 13))
            `CHK(logValid, 1'b1)
            ack();
        end
        regfileSelectCode = 4'h7;
    endtask : t_select

    // Every access code is carried through unchanged.
    task automatic t_access();
        for (int i = 0; i < 16; i++) begin
            accessKindCode = i[3:0];
            fire();
            `CHK(errorInfo[7:4], i[3:0])
            ack();
        end
    endtask : t_access

    // All flag combinations against the full word, reserved bits included.
    task automatic t_fields();
        for (int k = 0; k < 64; k++) begin
            regNumberValid       = k[0];
            instructionSetFlag   = k[1];
            instructionSetValid  = k[2];
            privilegeValid       = k[3];
            corrected            = k[4];
            precisePointerLogged = k[5];
            regNumber            = 7'(k * 37 + 5);
            privilegeLevelField  = 2'(k + 1);
            fire();
            `CHK(errorInfo, expWord())
            `CHK(errorInfo[62:60], 3'h0)
            `CHK(errorInfo[53:16], 38'h0)
            ack();
        end
    endtask : t_fields

    // Full log drops a second error, then an uncorrected one displaces a corrected one.
    task automatic t_overflow();
        corrected = 1'b0;
        regNumber = 7'h12;
        fire();
        held = expWord();
        regNumber = 7'h34;
        fire();
        `CHK(errorInfo, held)
        `CHK(overflow, 1'b1)
        ack();
        `CHK(overflow, 1'b0)
        corrected = 1'b1;
        fire();
        `CHK(errorInfo[59], 1'b1)
        corrected = 1'b0;
        fire();
        `CHK(errorInfo, expWord())
        `CHK(errorInfo[59], 1'b0)
        // Acknowledge and a new error in one cycle keep the new word.
        regNumber = 7'h7F;
        @(posedge clk);
        #1 readAck = 1'b1;
        errorEvent = 1'b1;
        @(posedge clk);
        #1 readAck = 1'b0;
        errorEvent = 1'b0;
        evCount++;
        `CHK(errorInfo, expWord())
        `CHK(logValid, 1'b1)
        `CHK(overflow, 1'b0)
        ack();
        `CHK(errorCount, 8'(evCount))
    endtask : t_overflow

    // A mid-run reset empties a full, overflowed log and restarts the count.
    task automatic t_reset();
        regfileSelectCode = 4'hF;
        regNumber = 7'h21;
        fire();
        fire();
        `CHK(selectWasReserved, 1'b1)
        `CHK(overflow, 1'b1)
        @(posedge clk);
        #1 rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
        `CHK(logValid, 1'b0)
        `CHK(overflow, 1'b0)
        `CHK(selectWasReserved, 1'b0)
        `CHK(errorInfo, 64'h0000_0000_0000_0000)
        `CHK(errorCount, 8'h00)
        fire();
        `CHK(errorCount, 8'h01)
        `CHK(errorInfo, expWord())
        ack();
    endtask : t_reset

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    // Reset for 12 cycles, check the cleared state, then run every scenario.
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        `CHK(errorInfo, 64'h0000_0000_0000_0000)
        `CHK(logValid, 1'b0)
        `CHK(overflow, 1'b0)
        `CHK(errorCount, 8'h00)
        t_select();
        t_access();
        t_fields();
        t_overflow();
        t_reset();
        closeOut();
    end

    // The whole run needs well under 1000 cycles, so 20000 means a hang.
    initial begin
        #200000;
        errTotal++;
        closeOut();
    end

endmodule : testbench
